// File: dv/opc_osc_pll_assertions.sv
`timescale 1ns/1ps
`include "opc_defines.vh"
// ---------------------------------------------------------------
// port checker for the oscillator and pll enable block
// ---------------------------------------------------------------
module opc_osc_pll_chk
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [3:0]  reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0]  sys_clk_src,
  input wire logic        lp_enter,
  input wire logic        lp_exit,
  input wire logic        pll_enable,
  input wire logic        pll_power_up,
  input wire logic        crystal_enable,
  input wire logic        crystal_power_up,
  input wire logic        crystal_bypass_en,
  input wire logic        rc_osc_enable,
  input wire logic        rc_rf_diff_clk_en,
  input wire logic        pll_source_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pll register accesses
  sequence pll_wr_s;
    reg_sel && reg_wr && reg_addr == `OPC_OFS_PLL && reg_be[1];
  endsequence
  sequence pll_rd_s;
    reg_sel && !reg_wr && reg_addr == `OPC_OFS_PLL;
  endsequence
  // enables, protections and register behaviour
  lp_entry_clear_a: assert property (
    lp_enter |=> !pll_enable && !pll_power_up && !crystal_enable)
    else $error("low-power entry left an enable set");
  pll_en_hold_a: assert property (
    sys_clk_src == `OPC_SYS_PLL && pll_enable && !lp_enter &&
    !pll_source_sel |=> pll_enable) else $error("pll enable dropped");
  pll_pu_hold_a: assert property (
    sys_clk_src == `OPC_SYS_PLL && pll_power_up && !lp_enter &&
    !pll_source_sel |=> pll_power_up) else $error("pll power dropped");
  rc_en_hold_a: assert property (
    sys_clk_src == `OPC_SYS_RC && rc_osc_enable |=> rc_osc_enable)
    else $error("rc enable dropped while in use");
  lp_exit_set_a: assert property (
    lp_exit |=> rc_osc_enable) else $error("rc enable not set on exit");
  rf_needs_rc_a: assert property (
    $rose(rc_rf_diff_clk_en) |-> $past(rc_osc_enable))
    else $error("rf clock set without rc enable");
  bypass_lock_a: assert property (
    $changed(crystal_bypass_en) |-> $past(!crystal_enable) &&
    $past(!crystal_power_up)) else $error("bypass changed with crystal on");
  pll_sel_wr_a: assert property (
    pll_wr_s |=> pll_source_sel == $past(reg_wdata[15]))
    else $error("pll source write lost");
  pll_rd_a: assert property (
    pll_rd_s |=> reg_rdata == {16'h0000, pll_source_sel, 15'h0000})
    else $error("pll register read wrong");
endmodule // opc_osc_pll_chk

bind opc_osc_pll_ctrl opc_osc_pll_chk u_chk (.clk(clk), .reset_n(reset_n),
  .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_clk_src(sys_clk_src),
  .lp_enter(lp_enter), .lp_exit(lp_exit), .pll_enable(pll_enable),
  .pll_power_up(pll_power_up), .crystal_enable(crystal_enable),
  .crystal_power_up(crystal_power_up),
  .crystal_bypass_en(crystal_bypass_en), .rc_osc_enable(rc_osc_enable),
  .rc_rf_diff_clk_en(rc_rf_diff_clk_en), .pll_source_sel(pll_source_sel));

// File: dv/opc_osc_pll_ctrl_test.sv
`timescale 1ns/1ps
`include "opc_defines.vh"
module opc_osc_pll_ctrl_test;
  logic clk = 0, reset_n = 0, sel = 0, wr = 0, lpi = 0, lpo = 0;
  logic xr = 0, rr = 1, xf = 0;
  logic [7:0] adr = 0;
  logic [3:0] be = 0;
  logic [31:0] wd = 0, rd;
  logic [1:0] src = `OPC_SYS_RC;
  logic [7:0] trim;
  logic pe, pp, xe, xp, bp, me, re, rf, ps, fr, xo;
  int errors = 0, cmp_count = 0;
  // ---------------------------------------------------------------
  // clock, device and watchdog
  // ---------------------------------------------------------------
  always #4 clk = ~clk;
  opc_osc_pll_ctrl u_dut (.clk(clk), .reset_n(reset_n), .reg_sel(sel),
    .reg_wr(wr), .reg_addr(adr), .reg_be(be), .reg_wdata(wd),
    .reg_rdata(rd), .sys_clk_src(src), .lp_enter(lpi), .lp_exit(lpo),
    .xtal_ready_raw(xr), .rc_ready_raw(rr), .xtal_fail_raw(xf),
    .xtal_stuck_raw(1'b0), .rc_cal_value(8'h5a), .ext_clk_in(1'b0),
    .xtal_osc_clk(1'b0), .xtal_out_clk(xo), .rc_trim(trim),
    .pll_enable(pe), .pll_power_up(pp), .crystal_enable(xe),
    .crystal_power_up(xp), .crystal_bypass_en(bp),
    .crystal_monitor_en(me), .rc_osc_enable(re), .rc_rf_diff_clk_en(rf),
    .pll_source_sel(ps), .force_sys_rc(fr));
  initial
  begin
    #100000;
    errors++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one register access, strobe held for one cycle
  task acc(input logic w, input logic [7:0] a, input logic [3:0] b,
           input logic [31:0] d);
    @(posedge clk);
    #1 sel = 1; wr = w; adr = a; be = b; wd = d;
    @(posedge clk);
    #1 sel = 0;
  endtask
  // one-cycle pulse on a low-power line
  task pulse(input logic ent);
    @(posedge clk);
    #1 if (ent) lpi = 1; else lpo = 1;
    @(posedge clk);
    #1 lpi = 0; lpo = 0;
  endtask
  task end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    repeat (4) @(posedge clk);
    acc(0, `OPC_OFS_CTL, 4'hf, 0);
    chk(rd, 32'h0000_5a83);
    acc(0, `OPC_OFS_PLL, 4'hf, 0);
    chk(rd, 32'h0000_0000);
    chk(trim, 8'h6a);
    $display("test reset done");
  endtask
  task t_regs;
    acc(1, `OPC_OFS_CTL, 4'h1, 32'h1d);
    // trim output is registered one cycle behind the adjust field
    @(posedge clk);
    #1 chk({rf, trim}, 9'h15d);
    acc(1, `OPC_OFS_PLL, 4'h2, 32'h0000_8000);
    acc(0, `OPC_OFS_PLL, 4'hf, 0);
    chk(rd, 32'h0000_8000);
    acc(0, 8'h0c, 4'hf, 0);
    chk(rd, 32'h0);
    $display("test regs done");
  endtask
  task t_prot;
    acc(1, `OPC_OFS_PLL, 4'h2, 0);
    acc(1, `OPC_OFS_CTL, 4'h4, 32'h0030_0000);
    src = `OPC_SYS_PLL;
    acc(1, `OPC_OFS_CTL, 4'hf, 32'h0004_0000);
    chk({pe, pp, bp, re}, 4'he);
    acc(1, `OPC_OFS_CTL, 4'h4, 32'h0045_0000);
    acc(1, `OPC_OFS_CTL, 4'h4, 32'h0041_0000);
    chk({xe, me, bp}, 3'h7);
    pulse(1);
    chk({pe, pp, xe, xp}, 4'h0);
    $display("test protect done");
  endtask
  task t_hw;
    src = `OPC_SYS_XTAL;
    acc(1, `OPC_OFS_CTL, 4'h5, 32'h0041_0000);
    xf = 1;
    repeat (5) @(posedge clk);
    chk(xe, 1'b0);
    xf = 0;
    chk(re, 1'b0);
    pulse(0);
    chk(re, 1'b1);
    $display("test hardware done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #1 reset_n = 1;
    t_reset;
    t_regs;
    t_prot;
    t_hw;
    end_sim;
  end
endmodule // opc_osc_pll_ctrl_test

// File: hdl/opc_defines.vh
`ifndef OPC_DEFINES_VH
`define OPC_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define OPC_OFS_CTL        8'h00
`define OPC_OFS_PLL        8'h04

// ----------------------------------------------------------------------
// oscillator_control field positions
// ----------------------------------------------------------------------
`define OPC_B_XTAL_PU      28
`define OPC_B_MON_EN       22
`define OPC_B_PLL_EN       21
`define OPC_B_PLL_PU       20
`define OPC_B_BYPASS       18
`define OPC_B_XTAL_STB     17
`define OPC_B_XTAL_EN      16
`define OPC_B_CAL_HI       15
`define OPC_B_CAL_LO       8
`define OPC_B_ADJ_HI       7
`define OPC_B_ADJ_LO       3
`define OPC_B_RF_EN        2
`define OPC_B_RC_STB       1
`define OPC_B_RC_EN        0

// ----------------------------------------------------------------------
// pll_source_select field, pll and adjust reset values
// ----------------------------------------------------------------------
`define OPC_B_PLL_SEL      15
`define OPC_PLL_RESET      32'h0000_0000
`define OPC_ADJ_RESET      5'h10

// ----------------------------------------------------------------------
// system clock source codes
// ----------------------------------------------------------------------
`define OPC_SYS_RC         2'h0
`define OPC_SYS_XTAL       2'h1
`define OPC_SYS_PLL        2'h2

`endif

// File: hdl/opc_osc_pll_ctrl.v
`timescale 1ns/1ps
`include "opc_defines.vh"

// What this block does
// RULE_01 - low-power entry clears pll and crystal enables
// RULE_02 - pll power-up not clearable while pll is sysclk
// RULE_03 - pll enable not clearable while pll is sysclk
// RULE_04 - bypass writable only with crystal off
// RULE_05 - bypass passes external clock as crystal output
// RULE_06 - crystal stable flag follows crystal readiness
// RULE_07 - crystal enable held while it feeds sysclk
// RULE_08 - forced crystal off under pll moves sysclk to rc
// RULE_09 - monitor failure clears crystal enable
// RULE_10 - monitored crystal failure disables crystal
// RULE_11 - rc calibration loaded at power-on
// RULE_12 - rc trim is adjust plus calibration
// RULE_13 - rf differential clock needs rc enable; a write that clears rc enable can leave rf set
// RULE_14 - rc stable flag follows rc readiness
// RULE_15 - rc enable held while rc is sysclk
// RULE_16 - low-power exit sets rc enable
// RULE_17 - stuck crystal under monitor sets rc enable
// RULE_18 - pll source bit picks rc or crystal
// RULE_19 - software keeps pll reserved bits at reset
// RULE_20 - pll register at 0x04, resets to zero
// RULE_21 - byte, half-word and word accesses supported; pll writes without byte 1 clear pll_source_sel
// RULE_22 - blocked bit keeps value, others update
// RULE_23 - hardware events win over software writes
module opc_osc_pll_ctrl
(
  input  wire        clk,
  input  wire        reset_n,
  input  wire        reg_sel,
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [3:0]  reg_be,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  input  wire [1:0]  sys_clk_src,
  input  wire        lp_enter,
  input  wire        lp_exit,
  input  wire        xtal_ready_raw,
  input  wire        rc_ready_raw,
  input  wire        xtal_fail_raw,
  input  wire        xtal_stuck_raw,
  input  wire [7:0]  rc_cal_value,
  input  wire        ext_clk_in,
  input  wire        xtal_osc_clk,
  output reg         xtal_out_clk,
  output reg  [7:0]  rc_trim,
  output reg         pll_enable,
  output reg         pll_power_up,
  output reg         crystal_enable,
  output reg         crystal_power_up,
  output reg         crystal_bypass_en,
  output reg         crystal_monitor_en,
  output reg         rc_osc_enable,
  output reg         rc_rf_diff_clk_en,
  output reg         pll_source_sel,
  output reg         force_sys_rc
);

  // --------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------
  // merge write data into a word under byte enables
  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer      i;
    begin
      be_merge = old_v;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          be_merge[i*8 +: 8] = new_v[i*8 +: 8];
    end
  endfunction

  // --------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        xo_s1_q;
  reg        xo_s2_q;
  wire       xtal_ready_s = sync2_q[0];
  wire       rc_ready_s   = sync2_q[1];
  wire       xtal_fail_s  = sync2_q[2];
  wire       xtal_stuck_s = sync2_q[3];
  wire       lp_s         = sync2_q[4];

  // two flops on the raw status and clock inputs, lp_enter and lp_exit used directly
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_q  <= 5'h00;
      sync2_q  <= 5'h00;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      xo_s1_q  <= 1'b0;
      xo_s2_q  <= 1'b0;
    end
    else
    begin
      sync1_q  <= {1'b0, xtal_stuck_raw, xtal_fail_raw,
                   rc_ready_raw, xtal_ready_raw};
      sync2_q  <= sync1_q;
      ext_s1_q <= ext_clk_in;
      ext_s2_q <= ext_s1_q;
      xo_s1_q  <= xtal_osc_clk;
      xo_s2_q  <= xo_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // calibration capture
  // --------------------------------------------------------------------
  reg        cal_done_q;
  reg  [7:0] cal_q;

  // latched once in the first cycle after reset release
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_done_q <= 1'b0;
      cal_q      <= 8'h00;
    end
    else if (!cal_done_q)
    begin
      cal_done_q <= 1'b1;
      cal_q      <= rc_cal_value; // [RULE_11]
    end
  end

  // --------------------------------------------------------------------
  // register write path
  // --------------------------------------------------------------------
  reg  [4:0] adj_q;
  wire       wr_ctl = reg_sel & reg_wr & (reg_addr == `OPC_OFS_CTL);
  wire       wr_pll = reg_sel & reg_wr & (reg_addr == `OPC_OFS_PLL); // [RULE_20]
  wire [31:0] ctl_cur;
  wire [31:0] ctl_new;
  wire [31:0] pll_new;
  wire       sys_pll  = (sys_clk_src == `OPC_SYS_PLL);
  wire       sys_xtal = (sys_clk_src == `OPC_SYS_XTAL);
  wire       sys_rc   = (sys_clk_src == `OPC_SYS_RC);
  wire       xtal_used = sys_xtal | (sys_pll & pll_source_sel);
  wire       lp_enter_s = lp_enter;
  wire       lp_exit_s  = lp_exit;
  wire       mon_fail = crystal_monitor_en & xtal_fail_s;

  assign ctl_cur = {3'h0, crystal_power_up, 5'h00, crystal_monitor_en,
                    pll_enable, pll_power_up, 1'b0, crystal_bypass_en,
                    1'b0, crystal_enable, cal_q, adj_q,
                    rc_rf_diff_clk_en, 1'b0, rc_osc_enable};
  assign ctl_new = be_merge(ctl_cur, reg_wdata, reg_be); // [RULE_21]
  assign pll_new = be_merge(`OPC_PLL_RESET, reg_wdata, reg_be);

  // software requests filtered by protection, hardware events override
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pll_enable         <= 1'b0;
      pll_power_up       <= 1'b0;
      crystal_enable     <= 1'b0;
      crystal_power_up   <= 1'b0;
      crystal_bypass_en  <= 1'b0;
      crystal_monitor_en <= 1'b0;
      rc_osc_enable      <= 1'b1;
      rc_rf_diff_clk_en  <= 1'b0;
      adj_q              <= `OPC_ADJ_RESET;
      pll_source_sel     <= 1'b0; // [RULE_20]
    end
    else
    begin
      if (wr_ctl)
      begin
        if (ctl_new[`OPC_B_PLL_EN] | ~sys_pll)
          pll_enable <= ctl_new[`OPC_B_PLL_EN]; // [RULE_03] [RULE_22]
        if (ctl_new[`OPC_B_PLL_PU] | ~sys_pll)
          pll_power_up <= ctl_new[`OPC_B_PLL_PU]; // [RULE_02]
        if (ctl_new[`OPC_B_XTAL_EN] | ~xtal_used)
          crystal_enable <= ctl_new[`OPC_B_XTAL_EN]; // [RULE_07]
        if (~crystal_enable)
          crystal_power_up <= ctl_new[`OPC_B_XTAL_PU];
        if (~crystal_enable & ~crystal_power_up)
          crystal_bypass_en <= ctl_new[`OPC_B_BYPASS]; // [RULE_04]
        crystal_monitor_en <= ctl_new[`OPC_B_MON_EN];
        adj_q <= ctl_new[`OPC_B_ADJ_HI:`OPC_B_ADJ_LO];
        if (ctl_new[`OPC_B_RC_EN] | ~sys_rc)
          rc_osc_enable <= ctl_new[`OPC_B_RC_EN]; // [RULE_15]
        rc_rf_diff_clk_en <= ctl_new[`OPC_B_RF_EN] &
                             rc_osc_enable; // [RULE_13]
      end
      if (wr_pll)
        pll_source_sel <= pll_new[`OPC_B_PLL_SEL]; // [RULE_18]
      // hardware events last so they win
      if (mon_fail)
        crystal_enable <= 1'b0; // [RULE_09] [RULE_10] [RULE_23]
      if (lp_enter_s)
      begin
        pll_enable       <= 1'b0; // [RULE_01]
        pll_power_up     <= 1'b0; // [RULE_01]
        crystal_enable   <= 1'b0; // [RULE_01]
        crystal_power_up <= 1'b0;
      end
      if (lp_exit_s | (crystal_monitor_en & xtal_stuck_s))
        rc_osc_enable <= 1'b1; // [RULE_16] [RULE_17] [RULE_23]
    end
  end

  // --------------------------------------------------------------------
  // status, trim, bypass and fallback outputs
  // --------------------------------------------------------------------
  reg        xtal_stb_q;
  reg        rc_stb_q;
  wire       xtal_drop = crystal_enable & ~crystal_bypass_en &
                         (mon_fail | lp_enter_s);

  // flags qualified by enables, registered outputs
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xtal_stb_q   <= 1'b0;
      rc_stb_q     <= 1'b0;
      rc_trim      <= 8'h00;
      xtal_out_clk <= 1'b0;
      force_sys_rc <= 1'b0;
    end
    else
    begin
      xtal_stb_q   <= crystal_enable & xtal_ready_s; // [RULE_06]
      rc_stb_q     <= rc_osc_enable & rc_ready_s; // [RULE_14]
      rc_trim      <= cal_q + {3'h0, adj_q}; // [RULE_12]
      xtal_out_clk <= crystal_bypass_en ? ext_s2_q : xo_s2_q; // [RULE_05]
      force_sys_rc <= (sys_pll & pll_source_sel &
                       (mon_fail | lp_enter_s)) |
                      (sys_xtal & xtal_drop); // [RULE_08]
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  // registered read data, unmapped reads as zero
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 32'h0000_0000;
    else if (reg_sel & ~reg_wr)
    begin
      if (reg_addr == `OPC_OFS_CTL)
        reg_rdata <= ctl_cur | {14'h0000, xtal_stb_q, 15'h0000,
                                rc_stb_q, 1'b0};
      else if (reg_addr == `OPC_OFS_PLL)
        reg_rdata <= {16'h0000, pll_source_sel, 15'h0000};
      else
        reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // opc_osc_pll_ctrl
